// *** dcf_map.svh ***
`ifndef DCF_MAP_SVH
`define DCF_MAP_SVH
// ----------------------------------------
// widths and queue depths
// ----------------------------------------
`define DCF_PTR_W 17
`define DCF_OFS_W 16
`define DCF_PTR_ONE 17'h00001
`define DCF_A2B_DEPTH 17'h04000
`define DCF_B2A_DEPTH 17'h10000
`define DCF_OFS_RST 16'h0008
`define DCF_FALL_THROUGH_MODE_RST 1'h0
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define DCF_ADR_W 8
`define DCF_REG_CTRL 8'h00
`define DCF_REG_A2B_AE 8'h04
`define DCF_REG_A2B_AF 8'h08
`define DCF_REG_B2A_AE 8'h0C
`define DCF_REG_B2A_AF 8'h10
`define DCF_REG_STATUS 8'h14
`define DCF_REG_A2B_CNT 8'h18
`define DCF_REG_B2A_CNT 8'h1C
// ----------------------------------------
// status bit positions
// ----------------------------------------
`define DCF_ST_FF_A 0
`define DCF_ST_FF_B 1
`define DCF_ST_EF_A 2
`define DCF_ST_EF_B 3
`define DCF_ST_AE_A 4
`define DCF_ST_AE_B 5
`define DCF_ST_AF_A 6
`define DCF_ST_AF_B 7
`endif

// *** dcf_pkg.sv ***
`include "dcf_map.svh"
package dcf_pkg;
    typedef logic [`DCF_PTR_W-1:0] dcf_ptr_t;
    typedef logic [`DCF_OFS_W-1:0] dcf_ofs_t;
    // index 0 is the a-to-b queue, index 1 the b-to-a queue
    typedef struct packed {
        logic port_a_clock;
        logic port_b_clock;
        logic [1:0][`DCF_PTR_W-1:0] wr_ptr;
        logic [1:0][`DCF_PTR_W-1:0] rd_ptr;
        logic [1:0] rdy;
        logic [1:0] load;
    } dcf_core_state_t;
    typedef struct packed {
        logic [`DCF_PTR_W-1:0] gray_src;
        logic [`DCF_PTR_W-1:0] stage1;
        logic [`DCF_PTR_W-1:0] stage2;
    } dcf_sync_state_t;
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic fall_through_mode;
        logic [1:0][`DCF_OFS_W-1:0] ae_ofs;
        logic [1:0][`DCF_OFS_W-1:0] af_ofs;
    } dcf_wb_state_t;
endpackage

// *** dcf_if.sv ***
`timescale 1ns/1ps
`include "dcf_map.svh"
// pointer handed from one port side to the other
interface dcf_ptr_if;
    logic [`DCF_PTR_W-1:0] ptr_next;
    logic dst_edge;
    logic [`DCF_PTR_W-1:0] ptr_sync;
    modport src (output ptr_next, output dst_edge, input ptr_sync);
    modport dst (input ptr_next, input dst_edge, output ptr_sync);
endinterface

// configuration out of the register file, status back into it
interface dcf_cfg_if;
    logic fall_through_mode;
    logic [1:0][`DCF_OFS_W-1:0] ae_ofs;
    logic [1:0][`DCF_OFS_W-1:0] af_ofs;
    logic [7:0] flags;
    logic [1:0][`DCF_PTR_W-1:0] count;
    modport regs (output fall_through_mode, output ae_ofs, output af_ofs, input flags, input count);
    modport core (input fall_through_mode, input ae_ofs, input af_ofs, output flags, output count);
endinterface

// *** dcf_ptr_sync.sv ***
`timescale 1ns/1ps
`include "dcf_map.svh"
module dcf_ptr_sync (
    input wire logic clk_in,
    input wire logic rst_n_in,
    dcf_ptr_if.dst link
);
    dcf_pkg::dcf_sync_state_t s_q;
    dcf_pkg::dcf_sync_state_t s_d;

    function automatic dcf_pkg::dcf_ptr_t gray2bin(input dcf_pkg::dcf_ptr_t g);
        dcf_pkg::dcf_ptr_t b;
        b = g;
        for (int i = `DCF_PTR_W - 2; i >= 0; i--) begin
            b[i] = b[i + 1] ^ g[i];
        end
        return b;
    endfunction

    // gray register at the source, two stages stepped by the far port clock
    always_comb begin
        s_d = s_q;
        s_d.gray_src = link.ptr_next ^ (link.ptr_next >> 1); // [R21]
        if (link.dst_edge) begin
            s_d.stage1 = s_q.gray_src; // [R21]
            s_d.stage2 = s_q.stage1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // only the second stage is decoded
    assign link.ptr_sync = gray2bin(s_q.stage2);

    gray_one_bit_a: assert property ( // [R21]
        @(posedge clk_in) disable iff (!rst_n_in)
        $countones(s_q.gray_src ^ $past(s_q.gray_src)) <= 1)
        else $error("source gray pointer moved more than one bit");
    sync_hold_a: assert property ( // [R21]
        @(posedge clk_in) disable iff (!rst_n_in)
        !link.dst_edge |=> $stable(s_q.stage2))
        else $error("synchronised pointer moved without a far clock edge");
endmodule

// *** dcf_wb_regs.sv ***
`timescale 1ns/1ps
`include "dcf_map.svh"
module dcf_wb_regs (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [`DCF_ADR_W-1:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    dcf_cfg_if.regs cfg
);
    dcf_pkg::dcf_wb_state_t s_q;
    dcf_pkg::dcf_wb_state_t s_d;

    // byte-lane merge of a 16-bit offset
    function automatic dcf_pkg::dcf_ofs_t merge(input dcf_pkg::dcf_ofs_t old);
        dcf_pkg::dcf_ofs_t v;
        v = old;
        if (wb_sel_in[0]) v[7:0] = wb_dat_in[7:0];
        if (wb_sel_in[1]) v[15:8] = wb_dat_in[15:8];
        return v;
    endfunction

    // ack one cycle after the strobe; writes land on the acked edge
    always_comb begin
        s_d = s_q;
        s_d.ack = 1'b0;
        if (wb_cyc_in && wb_stb_in && !s_q.ack) begin
            s_d.ack = 1'b1;
            case (wb_adr_in)
                `DCF_REG_CTRL: s_d.rdata = {31'h00000000, s_q.fall_through_mode};
                `DCF_REG_A2B_AE: s_d.rdata = {16'h0000, s_q.ae_ofs[0]};
                `DCF_REG_A2B_AF: s_d.rdata = {16'h0000, s_q.af_ofs[0]};
                `DCF_REG_B2A_AE: s_d.rdata = {16'h0000, s_q.ae_ofs[1]};
                `DCF_REG_B2A_AF: s_d.rdata = {16'h0000, s_q.af_ofs[1]};
                `DCF_REG_STATUS: s_d.rdata = {24'h000000, cfg.flags};
                `DCF_REG_A2B_CNT: s_d.rdata = {15'h0000, cfg.count[0]};
                `DCF_REG_B2A_CNT: s_d.rdata = {15'h0000, cfg.count[1]};
                default: s_d.rdata = 32'h00000000; // unmapped reads zero
            endcase
        end
        if (wb_cyc_in && wb_stb_in && s_q.ack && wb_we_in) begin
            case (wb_adr_in)
                `DCF_REG_CTRL: if (wb_sel_in[0]) s_d.fall_through_mode = wb_dat_in[0]; // [R03]
                `DCF_REG_A2B_AE: s_d.ae_ofs[0] = merge(s_q.ae_ofs[0]); // [R11]
                `DCF_REG_A2B_AF: s_d.af_ofs[0] = merge(s_q.af_ofs[0]); // [R12]
                `DCF_REG_B2A_AE: s_d.ae_ofs[1] = merge(s_q.ae_ofs[1]); // [R11]
                `DCF_REG_B2A_AF: s_d.af_ofs[1] = merge(s_q.af_ofs[1]); // [R12]
                default: s_d.fall_through_mode = s_q.fall_through_mode; // read-only or unmapped
            endcase
        end
    end

    // offsets come up at the preset value after reset
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            s_q.ack <= 1'b0;
            s_q.rdata <= 32'h00000000;
            s_q.fall_through_mode <= `DCF_FALL_THROUGH_MODE_RST;
            s_q.ae_ofs <= {2{`DCF_OFS_RST}};
            s_q.af_ofs <= {2{`DCF_OFS_RST}};
        end else begin
            s_q <= s_d;
        end
    end

    assign wb_ack_out = s_q.ack;
    assign wb_dat_out = s_q.rdata;
    assign cfg.fall_through_mode = s_q.fall_through_mode;
    assign cfg.ae_ofs = s_q.ae_ofs;
    assign cfg.af_ofs = s_q.af_ofs;
endmodule

// *** dcf_flags_top.sv ***
`timescale 1ns/1ps
`include "dcf_map.svh"
// What this block does
// R01 - write-port flag; accepted write bumps pointer
// R02 - almost-empty on read clock from pointer compare
// R03 - fall-through: ready flags; standard: empty/full
// R04 - full low means no room; writes dropped
// R05 - full rises second write edge after read
// R06 - late read shifts full rise one edge
// R07 - late write shifts empty rise one edge
// R08 - almost-empty high above offset words
// R09 - almost-empty rises second read edge after
// R10 - late write shifts almost-empty rise too
// R11 - a2b offset feeds port B almost-empty
// R12 - a2b almost-full offset feeds port A
// R13 - output register word not counted
// R14 - fall-through word frees its slot at once
// R15 - fall-through loads first word unrequested
// R16 - a2b flags follow word-count table
// R17 - b2a mirrors table, depth 65536
// R18 - ready rises third read edge, loads word
// R19 - empty flag rises second read edge
// R20 - reads dropped while empty/ready low
// R21 - crossing pointers gray, two stages
module dcf_flags_top (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic port_a_clock_in,
    input wire logic port_b_clock_in,
    input wire logic a_write_en_in,
    input wire logic a_read_en_in,
    input wire logic b_write_en_in,
    input wire logic b_read_en_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [`DCF_ADR_W-1:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    output logic full_ready_flag_port_a_out,
    output logic full_ready_flag_port_b_out,
    output logic empty_ready_flag_port_a_out,
    output logic empty_ready_flag_port_b_out,
    output logic almost_empty_flag_port_a_out,
    output logic almost_empty_flag_port_b_out,
    output logic almost_full_flag_port_a_out,
    output logic almost_full_flag_port_b_out,
    output logic a_out_reg_load_out,
    output logic b_out_reg_load_out
);
    // ----------------------------------------
    // state and per-queue views
    // ----------------------------------------
    dcf_pkg::dcf_core_state_t s_q;
    dcf_pkg::dcf_core_state_t s_d;
    logic a_edge;
    logic b_edge;
    logic fall_through_mode;
    logic [1:0] wedge;
    logic [1:0] redge;
    logic [1:0] wreq;
    logic [1:0] rreq;
    logic [1:0] full_ok;
    logic [1:0] mem_nz;
    logic [1:0] ae;
    logic [1:0] af;
    logic [1:0] ef;
    logic [1:0][`DCF_PTR_W-1:0] depth;
    logic [1:0][`DCF_PTR_W-1:0] wr_sync;
    logic [1:0][`DCF_PTR_W-1:0] rd_sync;
    logic [1:0][`DCF_PTR_W-1:0] cnt_w;
    logic [1:0][`DCF_PTR_W-1:0] cnt_r;

    dcf_cfg_if cfg();

    // ----------------------------------------
    // register file
    // ----------------------------------------
    dcf_wb_regs u_regs (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .wb_cyc_in(wb_cyc_in),
        .wb_stb_in(wb_stb_in),
        .wb_we_in(wb_we_in),
        .wb_adr_in(wb_adr_in),
        .wb_sel_in(wb_sel_in),
        .wb_dat_in(wb_dat_in),
        .wb_dat_out(wb_dat_out),
        .wb_ack_out(wb_ack_out),
        .cfg(cfg)
    );

    // port clocks are sampled pins; a rising edge is one step of that side
    assign a_edge = port_a_clock_in & ~s_q.port_a_clock;
    assign b_edge = port_b_clock_in & ~s_q.port_b_clock;
    assign fall_through_mode = cfg.fall_through_mode;

    // queue 0 is written on A and read on B, queue 1 the reverse
    assign wedge = {b_edge, a_edge}; // [R01]
    assign redge = {a_edge, b_edge}; // [R02]
    assign wreq = {b_write_en_in, a_write_en_in};
    assign rreq = {a_read_en_in, b_read_en_in};
    assign depth[0] = `DCF_A2B_DEPTH; // [R16]
    assign depth[1] = `DCF_B2A_DEPTH; // [R17]

    // ----------------------------------------
    // pointer update and output register control
    // ----------------------------------------
    // the read pointer steps whenever a word moves to the output register,
    // so a word parked there is already out of the memory count
    always_comb begin
        s_d = s_q;
        s_d.port_a_clock = port_a_clock_in;
        s_d.port_b_clock = port_b_clock_in;
        for (int q = 0; q < 2; q++) begin
            s_d.load[q] = 1'b0;
            if (wedge[q] && wreq[q] && full_ok[q]) begin
                s_d.wr_ptr[q] = s_q.wr_ptr[q] + `DCF_PTR_ONE; // [R01] [R04]
            end
            if (redge[q]) begin
                if (fall_through_mode) begin
                    if (!s_q.rdy[q]) begin
                        if (mem_nz[q]) begin
                            // unrequested fall-through frees the slot [R15] [R14] [R18]
                            s_d.rdy[q] = 1'b1;
                            s_d.load[q] = 1'b1;
                            s_d.rd_ptr[q] = s_q.rd_ptr[q] + `DCF_PTR_ONE; // [R13]
                        end
                    end else if (rreq[q]) begin
                        if (mem_nz[q]) begin
                            s_d.load[q] = 1'b1;
                            s_d.rd_ptr[q] = s_q.rd_ptr[q] + `DCF_PTR_ONE;
                        end else begin
                            s_d.rdy[q] = 1'b0; // last word taken
                        end
                    end
                end else begin
                    s_d.rdy[q] = 1'b0;
                    if (rreq[q] && mem_nz[q]) begin // [R20]
                        s_d.load[q] = 1'b1;
                        s_d.rd_ptr[q] = s_q.rd_ptr[q] + `DCF_PTR_ONE;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    // ----------------------------------------
    // per-queue crossing and flag compare
    // ----------------------------------------
    for (genvar q = 0; q < 2; q++) begin : g_queue
        dcf_ptr_if wr_x();
        dcf_ptr_if rd_x();

        // a pointer step seen on a same-cycle far edge waits one more edge
        assign wr_x.ptr_next = s_d.wr_ptr[q];
        assign wr_x.dst_edge = redge[q]; // [R07] [R10]
        assign rd_x.ptr_next = s_d.rd_ptr[q];
        assign rd_x.dst_edge = wedge[q]; // [R06]

        dcf_ptr_sync u_wr_sync (
            .clk_in(clk_in),
            .rst_n_in(rst_n_in),
            .link(wr_x)
        );
        dcf_ptr_sync u_rd_sync (
            .clk_in(clk_in),
            .rst_n_in(rst_n_in),
            .link(rd_x)
        );

        assign wr_sync[q] = wr_x.ptr_sync;
        assign rd_sync[q] = rd_x.ptr_sync;

        // write side sees the read pointer two write edges late [R05]
        assign cnt_w[q] = s_q.wr_ptr[q] - rd_sync[q];
        assign full_ok[q] = cnt_w[q] != depth[q]; // [R04] [R16]
        assign af[q] = cnt_w[q] < (depth[q] - {1'b0, cfg.af_ofs[q]}); // [R12] [R16]

        // read side sees the write pointer two read edges late [R19] [R09]
        assign cnt_r[q] = wr_sync[q] - s_q.rd_ptr[q];
        assign mem_nz[q] = cnt_r[q] != '0;
        assign ae[q] = cnt_r[q] > {1'b0, cfg.ae_ofs[q]}; // [R08] [R11]
        assign ef[q] = fall_through_mode ? s_q.rdy[q] : mem_nz[q]; // [R03]

        wr_advance_a: assert property ( // [R01]
            wedge[q] && wreq[q] && full_ok[q]
            |=> s_q.wr_ptr[q] == $past(s_q.wr_ptr[q]) + `DCF_PTR_ONE)
            else $error("accepted write did not bump the write pointer");
        wr_refused_a: assert property ( // [R04]
            wedge[q] && wreq[q] && !full_ok[q] |=> $stable(s_q.wr_ptr[q]))
            else $error("write taken while full");
        no_overflow_a: assert property ( // [R04]
            cnt_w[q] <= depth[q])
            else $error("write-side count above depth");
        full_rise_a: assert property ( // [R05]
            $rose(full_ok[q]) |-> $past(wedge[q]))
            else $error("full flag rose away from a write clock edge");
        ae_rise_a: assert property ( // [R09]
            $rose(ae[q]) && $stable(cfg.ae_ofs[q]) |-> $past(redge[q]))
            else $error("almost-empty rose away from a read clock edge");
        af_at_full_a: assert property ( // [R16]
            !full_ok[q] |-> !af[q])
            else $error("almost-full high while full");
        std_discard_a: assert property ( // [R20]
            redge[q] && !fall_through_mode && rreq[q] && !mem_nz[q]
            |=> $stable(s_q.rd_ptr[q]) && !s_q.load[q])
            else $error("read taken while empty");
        fall_through_a: assert property ( // [R15]
            redge[q] && fall_through_mode && !s_q.rdy[q] && mem_nz[q]
            |=> s_q.rdy[q] && s_q.load[q] && s_q.rd_ptr[q] != $past(s_q.rd_ptr[q]))
            else $error("first word did not fall through");

        fill_full_c: cover property (!full_ok[q]);
        ae_high_c: cover property ($rose(ae[q]));
        fall_through_mode_load_c: cover property (fall_through_mode && $rose(s_q.rdy[q]));
        std_read_c: cover property (!fall_through_mode && s_q.load[q]);
    end

    // ----------------------------------------
    // pins and status
    // ----------------------------------------
    assign full_ready_flag_port_a_out = full_ok[0];
    assign full_ready_flag_port_b_out = full_ok[1];
    assign empty_ready_flag_port_b_out = ef[0];
    assign empty_ready_flag_port_a_out = ef[1];
    assign almost_empty_flag_port_b_out = ae[0];
    assign almost_empty_flag_port_a_out = ae[1];
    assign almost_full_flag_port_a_out = af[0];
    assign almost_full_flag_port_b_out = af[1];
    assign b_out_reg_load_out = s_q.load[0];
    assign a_out_reg_load_out = s_q.load[1];

    assign cfg.flags[`DCF_ST_FF_A] = full_ok[0];
    assign cfg.flags[`DCF_ST_FF_B] = full_ok[1];
    assign cfg.flags[`DCF_ST_EF_A] = ef[1];
    assign cfg.flags[`DCF_ST_EF_B] = ef[0];
    assign cfg.flags[`DCF_ST_AE_A] = ae[1];
    assign cfg.flags[`DCF_ST_AE_B] = ae[0];
    assign cfg.flags[`DCF_ST_AF_A] = af[0];
    assign cfg.flags[`DCF_ST_AF_B] = af[1];
    // read-side memory counts, output register excluded
    assign cfg.count = cnt_r;
endmodule

// *** dcf_port_agent.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// far-side port user
// ----------------------------------------
// one port clock pulse per step request; the clock stands low between steps
module dcf_port_agent (
    input wire logic clk_in,
    input wire logic step_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic port_clock_out = 1'b0,
    output logic wr_en_out = 1'b0,
    output logic rd_en_out = 1'b0
);
    // enables change with the rising port clock and hold until the next step,
    // so they are stable on both sides of the edge the block samples
    always_ff @(posedge clk_in) begin
        port_clock_out <= step_in;
        if (step_in) begin
            wr_en_out <= wr_in;
            rd_en_out <= rd_in;
        end
    end
endmodule

// *** testbench.sv ***
`timescale 1ns/1ps
`include "dcf_map.svh"
module testbench;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic wb_cyc_in = 1'b0;
    logic wb_stb_in = 1'b0;
    logic wb_we_in = 1'b0;
    logic [7:0] wb_adr_in = 8'h00;
    logic [3:0] wb_sel_in = 4'h0;
    logic [31:0] wb_dat_in = 32'h00000000;
    logic [31:0] wb_dat_out;
    logic wb_ack_out;
    logic a_step = 1'b0;
    logic a_wr = 1'b0;
    logic a_rd = 1'b0;
    logic b_step = 1'b0;
    logic b_wr = 1'b0;
    logic b_rd = 1'b0;
    logic pa_clk, pb_clk, a_we, a_re, b_we, b_re;
    logic ff_a, ff_b, ef_a, ef_b, ae_a, ae_b, af_a, af_b, a_load, b_load;
    logic [7:0] flags;
    int mismatches = 0;
    int num_checks = 0;
    int a_loads = 0;
    int b_loads = 0;

    // flags packed in the same order as the status register
    assign flags = {af_b, af_a, ae_b, ae_a, ef_b, ef_a, ff_b, ff_a};

    initial begin
        forever #12.5 clk_in = ~clk_in;
    end

    dcf_port_agent u_dcf_port_agent_a (.clk_in(clk_in), .step_in(a_step), .wr_in(a_wr),
        .rd_in(a_rd), .port_clock_out(pa_clk), .wr_en_out(a_we), .rd_en_out(a_re));
    dcf_port_agent u_dcf_port_agent_b (.clk_in(clk_in), .step_in(b_step), .wr_in(b_wr),
        .rd_in(b_rd), .port_clock_out(pb_clk), .wr_en_out(b_we), .rd_en_out(b_re));
    dcf_flags_top u_dcf_flags_top (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .port_a_clock_in(pa_clk), .port_b_clock_in(pb_clk), .a_write_en_in(a_we),
        .a_read_en_in(a_re), .b_write_en_in(b_we), .b_read_en_in(b_re),
        .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
        .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
        .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
        .full_ready_flag_port_a_out(ff_a), .full_ready_flag_port_b_out(ff_b),
        .empty_ready_flag_port_a_out(ef_a), .empty_ready_flag_port_b_out(ef_b),
        .almost_empty_flag_port_a_out(ae_a), .almost_empty_flag_port_b_out(ae_b),
        .almost_full_flag_port_a_out(af_a), .almost_full_flag_port_b_out(af_b),
        .a_out_reg_load_out(a_load), .b_out_reg_load_out(b_load));

    // load pulses last one cycle, so they are counted rather than polled
    always @(posedge clk_in) begin
        if (a_load === 1'b1) a_loads++;
        if (b_load === 1'b1) b_loads++;
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task end_of_test;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask

    // classic cycle: hold everything until ack is sampled, then drop a cycle
    task wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                 output logic [31:0] rdat);
        int n;
        n = 0;
        @(posedge clk_in);
        wb_cyc_in <= 1'b1;
        wb_stb_in <= 1'b1;
        wb_we_in <= we;
        wb_adr_in <= adr;
        wb_sel_in <= 4'hF;
        wb_dat_in <= dat;
        do begin
            @(posedge clk_in);
            n++;
        end while (wb_ack_out !== 1'b1 && n < 100);
        rdat = wb_dat_out;
        if (n >= 100) begin
            mismatches++;
            $display("[ERR] %0t bus ack timeout", $time);
            end_of_test();
        end
        wb_cyc_in <= 1'b0;
        wb_stb_in <= 1'b0;
        @(posedge clk_in);
    endtask

    task wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] tmp;
        wb_xfer(1'b1, adr, dat, tmp);
    endtask

    task rd_chk(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] v;
        wb_xfer(1'b0, adr, 32'h00000000, v);
        chk(v, exp, "register read");
    endtask

    // side 0 is port A, 1 is port B; leaves three cycles after each taken edge
    task automatic port_step(input logic side, input logic w, input logic r, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_in);
            if (side) begin
                b_step <= 1'b1;
                b_wr <= w;
                b_rd <= r;
            end else begin
                a_step <= 1'b1;
                a_wr <= w;
                a_rd <= r;
            end
            @(posedge clk_in);
            a_step <= 1'b0;
            b_step <= 1'b0;
            repeat (3) @(posedge clk_in);
        end
        #1;
    endtask

    // ----------------------------------------
    // watchdog and main sequence
    // ----------------------------------------
    initial begin
        #(25 * 99000);
        mismatches++;
        $display("[ERR] %0t run timeout", $time);
        end_of_test();
    end

    initial begin
        repeat (20) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        #1;
        chk({24'h0, flags}, 32'h000000C3, "reset flags");
        rd_chk(`DCF_REG_CTRL, 32'h00000000);
        rd_chk(`DCF_REG_A2B_AE, 32'h00000008);
        rd_chk(`DCF_REG_B2A_AF, 32'h00000008);
        rd_chk(8'h20, 32'h00000000);
        rd_chk(`DCF_REG_STATUS, 32'h000000C3);
        $display("test reset done");
        // standard mode, one word through the a-to-b queue
        port_step(1'b0, 1'b1, 1'b0, 1);
        chk({24'h0, flags}, 32'h000000C3, "ef b after write");
        port_step(1'b1, 1'b0, 1'b0, 1);
        chk({24'h0, flags}, 32'h000000C3, "ef b first edge");
        port_step(1'b1, 1'b0, 1'b0, 1);
        chk({24'h0, flags}, 32'h000000CB, "ef b second edge");
        port_step(1'b1, 1'b0, 1'b1, 1);
        chk(b_loads, 32'h00000001, "b load count");
        chk({24'h0, flags}, 32'h000000C3, "ef b after read");
        port_step(1'b1, 1'b0, 1'b1, 1);
        chk(b_loads, 32'h00000001, "read while empty");
        $display("test standard done");
        // almost-empty threshold at two words
        wr(`DCF_REG_A2B_AE, 32'h00000002);
        port_step(1'b0, 1'b1, 1'b0, 3);
        port_step(1'b1, 1'b0, 1'b0, 1);
        chk({24'h0, flags}, 32'h000000C3, "ae b first edge");
        port_step(1'b1, 1'b0, 1'b0, 1);
        chk({24'h0, flags}, 32'h000000EB, "ae b above offset");
        rd_chk(`DCF_REG_STATUS, 32'h000000EB);
        port_step(1'b1, 1'b0, 1'b1, 1);
        chk({24'h0, flags}, 32'h000000CB, "ae b at offset");
        port_step(1'b1, 1'b0, 1'b1, 2);
        chk(b_loads, 32'h00000004, "b load count");
        chk({24'h0, flags}, 32'h000000C3, "a2b drained");
        $display("test almost empty done");
        // fall-through on the b-to-a queue
        wr(`DCF_REG_CTRL, 32'h00000001);
        port_step(1'b1, 1'b1, 1'b0, 1);
        port_step(1'b0, 1'b0, 1'b0, 2);
        chk({24'h0, flags}, 32'h000000C3, "ready a early");
        chk(a_loads, 32'h00000000, "a load early");
        port_step(1'b0, 1'b0, 1'b0, 1);
        chk({24'h0, flags}, 32'h000000C7, "ready a third edge");
        chk(a_loads, 32'h00000001, "unrequested load");
        rd_chk(`DCF_REG_B2A_CNT, 32'h00000000);
        port_step(1'b1, 1'b1, 1'b0, 1);
        port_step(1'b0, 1'b0, 1'b0, 2);
        rd_chk(`DCF_REG_B2A_CNT, 32'h00000001);
        // back to standard: the parked word is dropped, one word stays in memory
        wr(`DCF_REG_CTRL, 32'h00000000);
        chk({24'h0, flags}, 32'h000000C7, "ef a standard");
        port_step(1'b0, 1'b0, 1'b1, 1);
        chk(a_loads, 32'h00000002, "a load count");
        chk({24'h0, flags}, 32'h000000C3, "b2a drained");
        $display("test fall through done");
        // almost-full at depth minus 16380, then fill to full depth
        wr(`DCF_REG_A2B_AF, 32'h00003FFC);
        port_step(1'b0, 1'b1, 1'b0, 3);
        chk({24'h0, flags}, 32'h000000C3, "af a below");
        port_step(1'b0, 1'b1, 1'b0, 1);
        chk({24'h0, flags}, 32'h00000083, "af a reached");
        port_step(1'b0, 1'b1, 1'b0, 16379);
        chk({24'h0, flags}, 32'h00000083, "one slot left");
        port_step(1'b0, 1'b1, 1'b0, 1);
        chk({24'h0, flags}, 32'h00000082, "ff a full");
        port_step(1'b0, 1'b1, 1'b0, 1);
        port_step(1'b1, 1'b0, 1'b0, 2);
        chk({24'h0, flags}, 32'h000000AA, "full seen at b");
        rd_chk(`DCF_REG_A2B_CNT, 32'h00004000);
        port_step(1'b1, 1'b0, 1'b1, 1);
        port_step(1'b0, 1'b0, 1'b0, 1);
        chk({24'h0, flags}, 32'h000000AA, "ff a first edge");
        port_step(1'b0, 1'b0, 1'b0, 1);
        chk({24'h0, flags}, 32'h000000AB, "ff a second edge");
        $display("test full done");
        end_of_test();
    end
endmodule
